// >>> hw/dse_defines.svh
// Offsets, field positions, reset values and timing counts of the distance switch
`ifndef DSE_DEFINES_SVH
`define DSE_DEFINES_SVH

// Clock rate and time figures in their own units
`define DSE_CLK_HZ 125000000
`define DSE_MEAS_MS 8
`define DSE_TOGGLE_HZ 25
`define DSE_SETTLE_S 120
// Derived cycle counts (settle time: longest; toggle guard: rounded up)
`define DSE_MEAS_CYC ((`DSE_CLK_HZ / 1000) * `DSE_MEAS_MS)
`define DSE_TOGGLE_CYC ((`DSE_CLK_HZ + 2 * `DSE_TOGGLE_HZ - 1) / (2 * `DSE_TOGGLE_HZ))
`define DSE_SETTLE_CYC (64'(`DSE_SETTLE_S) * 64'(`DSE_CLK_HZ))

// Byte offsets of the register words
`define DSE_OFS_CTRL 6'h00
`define DSE_OFS_DP1 6'h04
`define DSE_OFS_RP1 6'h08
`define DSE_OFS_DP2 6'h0C
`define DSE_OFS_RP2 6'h10
`define DSE_OFS_REFL 6'h14
`define DSE_OFS_CMD 6'h18
`define DSE_OFS_STAT 6'h1C
`define DSE_OFS_PD 6'h20

// Control word fields
`define DSE_CTRL_MODE 1:0
`define DSE_CTRL_POL 2
`define DSE_CTRL_SYNC 3
`define DSE_CTRL_FILT 5:4
`define DSE_CTRL_STR 9:6
`define DSE_CTRL_IOL 10

// Distances in 0.1 mm units, strength and percentages
`define DSE_HYST 15'h0014
`define DSE_STR_MAX 4'h9
`define DSE_REFL_PCT 22'h0000_0055
`define DSE_OFFS_PCT 22'h0000_006C
`define DSE_PCT_DIV 22'h0000_0064

// Factory values
`define DSE_RST_POL 1'b0
`define DSE_RST_SYNC 1'b0
`define DSE_RST_STR 4'h0
`define DSE_RST_IOL 1'b0

`endif

// >>> hw/dse_pkg.sv
// Types shared by the distance switch evaluation logic
package dse_pkg;
	typedef enum logic [1:0] {mode_point, mode_window, mode_reflect} dse_mode_e;
	typedef enum logic [1:0] {unfiltered_setting, standard_hold_filter, averaging_filter} dse_filter_e;
	typedef enum logic [2:0] {cmd_none, cmd_teach_direct, cmd_teach_offset, cmd_teach_reflect,
		cmd_factory_restore} dse_cmd_e;
endpackage

// >>> hw/dse_top.sv
// Distance switch evaluation: filters, switching decision, teach-in and register slave
// Function
// - Single point mode: output on when distance drops below detect point
// - Window mode: output on only while distance is inside window bounds
// - Reflector mode: output on when object lies between sensor and reflector
// - Reflector mode: object counts only within 0 to 85 % of taught distance
// - Factory restore: point mode, open polarity, range, teach pin, standard filter, zero
// - Pin teach requests ignored while the pin is used for synchronisation
// - Temperature taken at power-up, applied only after 120 seconds
// - Direct teach stores the present distance as detect point
// - Offset teach stores a detect point 8 % farther than present distance
// - With detect point 1 set, output on below that point
// - Output returns inactive only above return point, detect point plus hysteresis
// - Writing point 2 pair enables window; return point 2 nearer than point 2
// - Output polarity selectable as normally open or normally closed
// - Unfiltered setting passes every raw measurement to the decision
// - Standard filter takes approach at once, holds on abrupt retreat
// - Averaging filter decides on the mean over strength-dependent sample count
// - Filter strength ranges from 0 weakest to 9 strongest
// - IO-Link mode sends distance in 0.1 mm with switch state cyclically
// - IO-Link mode disables pin teach and pin synchronisation
// - IO-Link mode starts measurements from the master cycle
// - Hysteresis 2 mm, toggling at most 25 Hz, response within 32 ms
// - Yellow indicator lit while the switched output is active
// - Process word: bit 0 switch state, bits 1 to 15 distance
//
// Our own choices: the Avalon-MM register port and the register offsets.
`include "dse_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dse_top #(
	parameter logic [14:0] OP_RANGE_DIST = 15'h0FA0, // Factory detect point
	parameter int MEAS_PERIOD_CYC = `DSE_MEAS_CYC, // Free-running measurement period
	parameter int TOGGLE_GUARD_CYC = `DSE_TOGGLE_CYC, // Least spacing of output changes
	parameter longint unsigned SETTLE_CYC = `DSE_SETTLE_CYC // Temperature settle time
) (
	input wire logic clk_i, // System clock
	input wire logic rst_b_i, // Asynchronous reset, active low
	input wire logic [5:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Low for the accepting cycle
	input wire logic meas_valid_i, // Pulse: new raw distance
	input wire logic [14:0] meas_dist_i, // Raw distance, 0.1 mm
	input wire logic temp_valid_i, // Pulse: temperature sample
	input wire logic [11:0] temp_code_i, // Temperature code
	input wire logic com_i, // Multi-function pin, asynchronous
	input wire logic iol_cycle_i, // Pulse: master protocol cycle
	output logic meas_trig_o, // Pulse: start a measurement
	output logic switch_o, // Switched output after polarity
	output logic led_yellow_o, // Yellow indicator
	output logic [15:0] pd_o, // Process data word
	output logic [11:0] temp_comp_o, // Applied compensation value
	output logic temp_applied_o // Compensation in force
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	dse_pkg::dse_mode_e mode_reg;
	dse_pkg::dse_filter_e filt_reg;
	logic pol_reg, sync_reg, iol_reg;
	logic [3:0] str_reg;
	logic [14:0] dp1_reg, rp1_reg, dp2_reg, rp2_reg, refl_reg;
	logic [14:0] filt_d_reg;
	logic filt_v_reg;
	logic [3:0] hold_cnt_reg, avg_n_reg;
	logic [18:0] acc_reg;
	logic state_reg;
	logic [31:0] guard_cnt_reg, per_cnt_reg;
	logic com_s1_reg, com_s2_reg, com_s3_reg, com_lvl_reg, com_rise_reg;
	logic [11:0] temp_held_reg;
	logic temp_got_reg;
	logic [35:0] settle_cnt_reg;

	// Bus handshake and address decode
	wire bus_req = avs_read_i | avs_write_i;
	wire wr_fire = avs_write_i & ~avs_waitrequest_o;
	wire sel_ctrl = avs_address_i == `DSE_OFS_CTRL;
	wire sel_dp1 = avs_address_i == `DSE_OFS_DP1;
	wire sel_rp1 = avs_address_i == `DSE_OFS_RP1;
	wire sel_dp2 = avs_address_i == `DSE_OFS_DP2;
	wire sel_rp2 = avs_address_i == `DSE_OFS_RP2;
	wire sel_refl = avs_address_i == `DSE_OFS_REFL;
	wire sel_cmd = avs_address_i == `DSE_OFS_CMD;
	wire sel_stat = avs_address_i == `DSE_OFS_STAT;
	wire sel_pd = avs_address_i == `DSE_OFS_PD;

	// Read selection; unmapped words read as zero
	wire [31:0] ctrl_rd = {21'h0_0000, iol_reg, str_reg, filt_reg, sync_reg, pol_reg, mode_reg};
	wire [31:0] rd_mux = sel_ctrl ? ctrl_rd :
		sel_dp1 ? {17'h0_0000, dp1_reg} :
		sel_rp1 ? {17'h0_0000, rp1_reg} :
		sel_dp2 ? {17'h0_0000, dp2_reg} :
		sel_rp2 ? {17'h0_0000, rp2_reg} :
		sel_refl ? {17'h0_0000, refl_reg} :
		sel_stat ? {15'h0000, temp_applied_o, filt_d_reg, led_yellow_o} :
		sel_pd ? {16'h0000, pd_o} : 32'h0000_0000;

	// One wait cycle per access; read data stand at the accepting edge
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
			if (avs_read_i && avs_waitrequest_o)
				avs_readdata_o <= rd_mux;
		end
	end

	// Pin synchroniser; a level counts once stages two and three agree
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			com_s1_reg <= 1'b0;
			com_s2_reg <= 1'b0;
			com_s3_reg <= 1'b0;
			com_lvl_reg <= 1'b0;
			com_rise_reg <= 1'b0;
		end
		else
		begin
			com_s1_reg <= com_i;
			com_s2_reg <= com_s1_reg;
			com_s3_reg <= com_s2_reg;
			if (com_s2_reg == com_s3_reg)
				com_lvl_reg <= com_s3_reg;
			com_rise_reg <= (com_s2_reg == com_s3_reg) && com_s3_reg && !com_lvl_reg;
		end
	end

	// Commands; the pin only teaches when it is neither sync nor in IO-Link mode
	wire cmd_fire = wr_fire & sel_cmd;
	wire [2:0] cmd_code = avs_writedata_i[2:0];
	wire pin_teach = com_rise_reg && !sync_reg && !iol_reg;
	wire do_factory = cmd_fire && cmd_code == dse_pkg::cmd_factory_restore;
	wire do_direct = (cmd_fire && cmd_code == dse_pkg::cmd_teach_direct) || pin_teach;
	wire do_offset = cmd_fire && cmd_code == dse_pkg::cmd_teach_offset;
	wire do_refl = cmd_fire && cmd_code == dse_pkg::cmd_teach_reflect;

	// Taught points; saturation keeps far targets from wrapping to near ones
	wire [21:0] offs_q = (22'(filt_d_reg) * `DSE_OFFS_PCT) / `DSE_PCT_DIV;
	wire [14:0] offs_dist = (|offs_q[21:15]) ? 15'h7FFF : offs_q[14:0];
	wire [15:0] dir_ret = 16'(filt_d_reg) + 16'(`DSE_HYST);
	wire [15:0] offs_ret = 16'(offs_dist) + 16'(`DSE_HYST);
	wire [14:0] dir_rp = dir_ret[15] ? 15'h7FFF : dir_ret[14:0];
	wire [14:0] offs_rp = offs_ret[15] ? 15'h7FFF : offs_ret[14:0];
	wire [3:0] str_wr = (avs_writedata_i[`DSE_CTRL_STR] > `DSE_STR_MAX) ?
		`DSE_STR_MAX : avs_writedata_i[`DSE_CTRL_STR];
	wire [1:0] mode_raw = avs_writedata_i[`DSE_CTRL_MODE];
	wire [1:0] filt_raw = avs_writedata_i[`DSE_CTRL_FILT];
	wire dse_pkg::dse_mode_e mode_wr = (mode_raw == 2'h3) ? dse_pkg::mode_point :
		dse_pkg::dse_mode_e'(mode_raw);
	wire dse_pkg::dse_filter_e filt_wr = (filt_raw == 2'h3) ? dse_pkg::standard_hold_filter :
		dse_pkg::dse_filter_e'(filt_raw);

	// Configuration: factory restore beats teach, teach beats bus write
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mode_reg <= dse_pkg::mode_point;
			pol_reg <= `DSE_RST_POL;
			sync_reg <= `DSE_RST_SYNC;
			filt_reg <= dse_pkg::standard_hold_filter;
			str_reg <= `DSE_RST_STR;
			iol_reg <= `DSE_RST_IOL;
			dp1_reg <= OP_RANGE_DIST;
			rp1_reg <= 15'(OP_RANGE_DIST + `DSE_HYST);
			dp2_reg <= 15'h0000;
			rp2_reg <= 15'h0000;
			refl_reg <= OP_RANGE_DIST;
		end
		else if (do_factory)
		begin
			mode_reg <= dse_pkg::mode_point;
			pol_reg <= `DSE_RST_POL;
			sync_reg <= `DSE_RST_SYNC;
			filt_reg <= dse_pkg::standard_hold_filter;
			str_reg <= `DSE_RST_STR;
			iol_reg <= `DSE_RST_IOL;
			dp1_reg <= OP_RANGE_DIST;
			rp1_reg <= 15'(OP_RANGE_DIST + `DSE_HYST);
			dp2_reg <= 15'h0000;
			rp2_reg <= 15'h0000;
			refl_reg <= OP_RANGE_DIST;
		end
		else if (do_direct || do_offset)
		begin
			mode_reg <= dse_pkg::mode_point;
			dp1_reg <= do_offset ? offs_dist : filt_d_reg;
			rp1_reg <= do_offset ? offs_rp : dir_rp;
		end
		else if (do_refl)
		begin
			mode_reg <= dse_pkg::mode_reflect;
			refl_reg <= filt_d_reg;
		end
		else if (wr_fire)
		begin
			if (sel_ctrl)
			begin
				mode_reg <= mode_wr;
				pol_reg <= avs_writedata_i[`DSE_CTRL_POL];
				sync_reg <= avs_writedata_i[`DSE_CTRL_SYNC];
				filt_reg <= filt_wr;
				str_reg <= str_wr;
				iol_reg <= avs_writedata_i[`DSE_CTRL_IOL];
			end
			if (sel_dp1)
				dp1_reg <= avs_writedata_i[14:0];
			if (sel_rp1)
				rp1_reg <= avs_writedata_i[14:0];
			if (sel_dp2 || sel_rp2)
				mode_reg <= dse_pkg::mode_window;
			if (sel_dp2)
				dp2_reg <= avs_writedata_i[14:0];
			if (sel_rp2)
				rp2_reg <= avs_writedata_i[14:0];
			if (sel_refl)
				refl_reg <= avs_writedata_i[14:0];
		end
	end

	// Measurement start: master cycle, sync pin edge, or own period
	wire per_end = per_cnt_reg >= 32'(MEAS_PERIOD_CYC - 1);
	wire trig_src = iol_reg ? iol_cycle_i : (sync_reg ? com_rise_reg : per_end);
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			per_cnt_reg <= 32'h0000_0000;
			meas_trig_o <= 1'b0;
		end
		else
		begin
			per_cnt_reg <= per_end ? 32'h0000_0000 : per_cnt_reg + 32'h0000_0001;
			meas_trig_o <= trig_src;
		end
	end

	// Filter stage: strength sets hold length or averaging count
	wire take_std = (meas_dist_i <= filt_d_reg) || (hold_cnt_reg >= str_reg);
	wire [18:0] acc_sum = acc_reg + 19'(meas_dist_i);
	wire avg_last = avg_n_reg >= str_reg;
	wire [18:0] avg_q = acc_sum / 19'(str_reg + 4'h1);
	wire is_avg = filt_reg == dse_pkg::averaging_filter;
	wire is_std = filt_reg == dse_pkg::standard_hold_filter;
	wire [14:0] filt_d_next = is_avg ? avg_q[14:0] :
		(is_std && !take_std) ? filt_d_reg : meas_dist_i;
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			filt_d_reg <= 15'h7FFF;
			filt_v_reg <= 1'b0;
			hold_cnt_reg <= 4'h0;
			avg_n_reg <= 4'h0;
			acc_reg <= 19'h0_0000;
		end
		else
		begin
			filt_v_reg <= meas_valid_i && (!is_avg || avg_last);
			if (meas_valid_i && (!is_avg || avg_last))
				filt_d_reg <= filt_d_next;
			if (meas_valid_i)
			begin
				hold_cnt_reg <= (take_std || !is_std) ? 4'h0 : hold_cnt_reg + 4'h1;
				avg_n_reg <= (avg_last || !is_avg) ? 4'h0 : avg_n_reg + 4'h1;
				acc_reg <= (avg_last || !is_avg) ? 19'h0_0000 : acc_sum;
			end
		end
	end

	// Switching decision with hysteresis per mode
	wire [21:0] refl_thr_w = (22'(refl_reg) * `DSE_REFL_PCT) / `DSE_PCT_DIV;
	wire [14:0] refl_thr = refl_thr_w[14:0];
	wire [15:0] refl_off = 16'(refl_thr) + 16'(`DSE_HYST);
	wire on_pt = filt_d_reg < dp1_reg;
	wire off_pt = filt_d_reg > rp1_reg;
	wire on_win = on_pt && filt_d_reg > dp2_reg;
	wire off_win = off_pt || filt_d_reg < rp2_reg;
	wire on_ref = filt_d_reg <= refl_thr;
	wire off_ref = 16'(filt_d_reg) > refl_off;
	wire on_sel = (mode_reg == dse_pkg::mode_window) ? on_win :
		(mode_reg == dse_pkg::mode_reflect) ? on_ref : on_pt;
	wire off_sel = (mode_reg == dse_pkg::mode_window) ? off_win :
		(mode_reg == dse_pkg::mode_reflect) ? off_ref : off_pt;
	wire eval_next = on_sel ? 1'b1 : (off_sel ? 1'b0 : state_reg);
	wire change_ok = (eval_next != state_reg) && (guard_cnt_reg == 32'h0000_0000);
	wire state_upd = change_ok ? eval_next : state_reg;

	// Output, indicator and process word move together; guard caps toggle rate
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg <= 1'b0;
			guard_cnt_reg <= 32'h0000_0000;
			switch_o <= `DSE_RST_POL;
			led_yellow_o <= 1'b0;
			pd_o <= 16'h0000;
		end
		else
		begin
			if (filt_v_reg && change_ok)
				guard_cnt_reg <= 32'(TOGGLE_GUARD_CYC);
			else if (guard_cnt_reg != 32'h0000_0000)
				guard_cnt_reg <= guard_cnt_reg - 32'h0000_0001;
			if (filt_v_reg)
			begin
				state_reg <= state_upd;
				switch_o <= state_upd ^ pol_reg;
				led_yellow_o <= state_upd;
				pd_o <= {filt_d_reg, state_upd};
			end
		end
	end

	// Temperature: first sample is held, applied only after the settle time
	wire settle_done = settle_cnt_reg >= 36'(SETTLE_CYC);
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			settle_cnt_reg <= 36'h0_0000_0000;
			temp_held_reg <= 12'h000;
			temp_got_reg <= 1'b0;
			temp_comp_o <= 12'h000;
			temp_applied_o <= 1'b0;
		end
		else
		begin
			if (!settle_done)
				settle_cnt_reg <= settle_cnt_reg + 36'h0_0000_0001;
			if (temp_valid_i && !temp_got_reg)
			begin
				temp_held_reg <= temp_code_i;
				temp_got_reg <= 1'b1;
			end
			if (settle_done && temp_got_reg)
			begin
				temp_comp_o <= temp_held_reg;
				temp_applied_o <= 1'b1;
			end
		end
	end

	// Checks on the decision, teach, filter, packing, temperature and trigger
	property p_point_on;
		filt_v_reg && mode_reg == dse_pkg::mode_point && on_pt && guard_cnt_reg == 0
			|=> led_yellow_o;
	endproperty
	a_point_on: assert property (p_point_on) else $error("point mode failed to switch on");
	property p_window_off;
		filt_v_reg && mode_reg == dse_pkg::mode_window && !on_win && off_win
			&& guard_cnt_reg == 0 |=> !led_yellow_o;
	endproperty
	a_window_off: assert property (p_window_off) else $error("window exit not seen");
	property p_refl_on;
		filt_v_reg && mode_reg == dse_pkg::mode_reflect && on_ref && guard_cnt_reg == 0
			|=> led_yellow_o;
	endproperty
	a_refl_on: assert property (p_refl_on) else $error("reflector target missed");
	property p_polarity;
		filt_v_reg |=> switch_o == (led_yellow_o ^ $past(pol_reg));
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity wrong");
	property p_sync_no_teach;
		sync_reg && com_rise_reg && !wr_fire |=> $stable(dp1_reg);
	endproperty
	a_sync_no_teach: assert property (p_sync_no_teach) else $error("teach in sync mode");
	property p_teach_direct;
		cmd_fire && cmd_code == dse_pkg::cmd_teach_direct |=> dp1_reg == $past(filt_d_reg);
	endproperty
	a_teach_direct: assert property (p_teach_direct) else $error("direct teach value");
	property p_strength_max;
		str_reg <= `DSE_STR_MAX;
	endproperty
	a_strength_max: assert property (p_strength_max) else $error("strength above 9");
	property p_pd_pack;
		filt_v_reg |=> pd_o == {$past(filt_d_reg), led_yellow_o};
	endproperty
	a_pd_pack: assert property (p_pd_pack) else $error("process word packing");
	property p_std_take;
		is_std && meas_valid_i && meas_dist_i < filt_d_reg |=> ##1 filt_d_reg == $past(meas_dist_i, 2);
	endproperty
	a_std_take: assert property (p_std_take) else $error("approach not taken");
	property p_temp_wait;
		temp_applied_o |-> settle_done;
	endproperty
	a_temp_wait: assert property (p_temp_wait) else $error("temperature applied early");
	property p_iol_trig;
		iol_reg && iol_cycle_i |=> meas_trig_o;
	endproperty
	a_iol_trig: assert property (p_iol_trig) else $error("no trigger on master cycle");

endmodule // dse_top

`default_nettype wire

// >>> tb/dse_partner.sv
// Far-side model: measurement source, temperature source, pin driver and master cycle
`timescale 1ns/1ps
`default_nettype none

module dse_partner (
	input wire logic clk_i, // System clock
	output logic meas_valid_o, // Sample strobe
	output logic [14:0] meas_dist_o, // Raw distance, 0.1 mm
	output logic temp_valid_o, // Temperature strobe
	output logic [11:0] temp_code_o, // Temperature code
	output logic com_o, // Multi-function pin
	output logic iol_cycle_o // Master cycle pulse
);
	// Idle levels at time zero
	initial
	begin
		meas_valid_o = 1'b0;
		meas_dist_o = 15'h7FFF;
		temp_valid_o = 1'b0;
		temp_code_o = 12'hFFF;
		com_o = 1'b0;
		iol_cycle_o = 1'b0;
	end

	// One sample; released data shows the inverse so a stale value never passes
	task automatic send_meas(input logic [14:0] d);
		@(posedge clk_i);
		meas_valid_o <= 1'b1;
		meas_dist_o <= d;
		@(posedge clk_i);
		meas_valid_o <= 1'b0;
		meas_dist_o <= ~d;
		repeat (7) @(posedge clk_i);
		#1;
	endtask

	// Temperature taken once after power-up
	task automatic send_temp(input logic [11:0] c);
		@(posedge clk_i);
		temp_valid_o <= 1'b1;
		temp_code_o <= c;
		@(posedge clk_i);
		temp_valid_o <= 1'b0;
		temp_code_o <= ~c;
		#1;
	endtask

	// Pin pulse long enough to pass the synchroniser
	task automatic pin_pulse();
		@(posedge clk_i);
		com_o <= 1'b1;
		repeat (10) @(posedge clk_i);
		com_o <= 1'b0;
		repeat (10) @(posedge clk_i);
		#1;
	endtask

	// Single master protocol cycle
	task automatic master_cycle();
		@(posedge clk_i);
		iol_cycle_o <= 1'b1;
		@(posedge clk_i);
		iol_cycle_o <= 1'b0;
	endtask
endmodule // dse_partner

`default_nettype wire

// >>> tb/distance_switch_evaluation_tb_top.sv
// Self-checking bench of the distance switch evaluation block
`include "dse_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module distance_switch_evaluation_tb_top;
	logic clk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [5:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rdv;
	logic meas_valid_i, temp_valid_i, com_i, iol_cycle_i, meas_trig_o;
	logic switch_o, led_yellow_o, temp_applied_o;
	logic [14:0] meas_dist_i;
	logic [11:0] temp_code_i, temp_comp_o;
	logic [15:0] pd_o;
	int fail_count, n_checks, trigs;

	// Short counts keep the run brief; expectations use the same figures
	dse_top #(.MEAS_PERIOD_CYC(50), .TOGGLE_GUARD_CYC(4), .SETTLE_CYC(100)) dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.meas_valid_i(meas_valid_i), .meas_dist_i(meas_dist_i), .temp_valid_i(temp_valid_i),
		.temp_code_i(temp_code_i), .com_i(com_i), .iol_cycle_i(iol_cycle_i),
		.meas_trig_o(meas_trig_o), .switch_o(switch_o), .led_yellow_o(led_yellow_o),
		.pd_o(pd_o), .temp_comp_o(temp_comp_o), .temp_applied_o(temp_applied_o));

	dse_partner part (
		.clk_i(clk_i), .meas_valid_o(meas_valid_i), .meas_dist_o(meas_dist_i),
		.temp_valid_o(temp_valid_i), .temp_code_o(temp_code_i), .com_o(com_i),
		.iol_cycle_o(iol_cycle_i));

	// Clock of 8 ns
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Avalon transfer held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_address_i <= a;
		avs_writedata_i <= wd;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 50);
		rdv = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk("register", rdv, exp);
	endtask

	// Output group after one sample
	task automatic meas_out(input logic [14:0] d, input logic st, input logic pol);
		part.send_meas(d);
		chk("switch", switch_o, st ^ pol);
		chk("led", led_yellow_o, st);
		chk("pd", pd_o, {d, st});
	endtask

	task automatic sc_temp();
		part.send_temp(12'h5A3);
		chk("applied early", temp_applied_o, 1'b0);
		repeat (150) @(posedge clk_i);
		#1;
		chk("applied", temp_applied_o, 1'b1);
		chk("comp", temp_comp_o, 12'h5A3);
	endtask

	task automatic sc_point();
		rd(`DSE_OFS_CTRL, 32'h0000_0010);
		rd(`DSE_OFS_DP1, 32'h0000_0FA0);
		rd(6'h3C, 32'h0000_0000);
		wr(`DSE_OFS_CTRL, 32'h0000_0000);
		wr(`DSE_OFS_DP1, 32'h0000_03E8);
		wr(`DSE_OFS_RP1, 32'h0000_03FC);
		meas_out(15'h044C, 1'b0, 1'b0);
		meas_out(15'h0384, 1'b1, 1'b0);
		meas_out(15'h03F2, 1'b1, 1'b0);
		meas_out(15'h0406, 1'b0, 1'b0);
		wr(`DSE_OFS_CTRL, 32'h0000_0004);
		meas_out(15'h0384, 1'b1, 1'b1);
	endtask

	task automatic sc_teach();
		wr(`DSE_OFS_CTRL, 32'h0000_0000);
		part.send_meas(15'h07D0);
		wr(`DSE_OFS_CMD, 32'h0000_0001);
		rd(`DSE_OFS_DP1, 32'h0000_07D0);
		rd(`DSE_OFS_RP1, 32'h0000_07E4);
		wr(`DSE_OFS_CMD, 32'h0000_0002);
		rd(`DSE_OFS_DP1, 32'h0000_0870);
		wr(`DSE_OFS_CMD, 32'h0000_0003);
		rd(`DSE_OFS_REFL, 32'h0000_07D0);
		part.send_meas(15'h05DC);
		part.pin_pulse();
		rd(`DSE_OFS_DP1, 32'h0000_05DC);
		wr(`DSE_OFS_CTRL, 32'h0000_0008);
		part.send_meas(15'h04B0);
		part.pin_pulse();
		rd(`DSE_OFS_DP1, 32'h0000_05DC);
	endtask

	task automatic sc_window();
		wr(`DSE_OFS_CTRL, 32'h0000_0000);
		wr(`DSE_OFS_DP1, 32'h0000_03E8);
		wr(`DSE_OFS_RP1, 32'h0000_03FC);
		wr(`DSE_OFS_DP2, 32'h0000_01F4);
		wr(`DSE_OFS_RP2, 32'h0000_01E0);
		rd(`DSE_OFS_CTRL, 32'h0000_0001);
		meas_out(15'h02BC, 1'b1, 1'b0);
		meas_out(15'h0190, 1'b0, 1'b0);
		meas_out(15'h02BC, 1'b1, 1'b0);
		meas_out(15'h0406, 1'b0, 1'b0);
	endtask

	task automatic sc_reflect();
		wr(`DSE_OFS_CTRL, 32'h0000_0002);
		wr(`DSE_OFS_REFL, 32'h0000_03E8);
		meas_out(15'h0384, 1'b0, 1'b0);
		meas_out(15'h0352, 1'b1, 1'b0);
		meas_out(15'h0384, 1'b0, 1'b0);
	endtask

	task automatic sc_filter();
		wr(`DSE_OFS_CTRL, 32'h0000_0090);
		part.send_meas(15'h01F4);
		chk("dist", pd_o[15:1], 15'h01F4);
		part.send_meas(15'h05DC);
		chk("dist held", pd_o[15:1], 15'h01F4);
		wr(`DSE_OFS_CTRL, 32'h0000_0060);
		part.send_meas(15'h0258);
		part.send_meas(15'h0258);
		part.send_meas(15'h0190);
		part.send_meas(15'h0258);
		chk("mean", pd_o[15:1], 15'h01F4);
		wr(`DSE_OFS_CTRL, 32'h0000_0300);
		rd(`DSE_OFS_CTRL, 32'h0000_0240);
	endtask

	task automatic sc_iol();
		wr(`DSE_OFS_CTRL, 32'h0000_0400);
		// A period trigger launched on the accepting edge may still show for one cycle
		@(posedge clk_i);
		trigs = 0;
		repeat (60)
		begin
			@(posedge clk_i);
			if (meas_trig_o === 1'b1)
				trigs++;
		end
		chk("free trig", trigs, 0);
		part.master_cycle();
		trigs = 0;
		repeat (4)
		begin
			@(posedge clk_i);
			if (meas_trig_o === 1'b1)
				trigs++;
		end
		chk("cycle trig", trigs, 1);
		part.send_meas(15'h0300);
		part.pin_pulse();
		rd(`DSE_OFS_DP1, 32'h0000_03E8);
		wr(`DSE_OFS_CMD, 32'h0000_0004);
		rd(`DSE_OFS_CTRL, 32'h0000_0010);
		rd(`DSE_OFS_DP1, 32'h0000_0FA0);
	endtask

	// Main sequence
	initial
	begin
		fail_count = 0;
		n_checks = 0;
		rst_b_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 6'h00;
		avs_writedata_i = 32'h0000_0000;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		sc_temp();
		sc_point();
		sc_teach();
		sc_window();
		sc_reflect();
		sc_filter();
		sc_iol();
		tally_and_finish();
	end

	// Watchdog well beyond the several hundred cycles the sequence needs
	initial
	begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		tally_and_finish();
	end
endmodule // distance_switch_evaluation_tb_top

`default_nettype wire
